// *** dv/sfcu_host.sv ***
// ================================================================
// Serial bus master: sends framed characters, collects replies
module sfcu_host #(
  parameter int GAP = 100000
) (
  // Clock
  input wire logic       clk,
  // Characters toward the device
  output logic           rx_valid,
  output logic [7:0]     rx_data,
  input wire logic       rx_ready,
  // Characters from the device
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  output logic           tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       slow = 1'b0;
  logic [7:0] got[$];

  // Nothing offered at start
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Collect taken characters; a slow reader simply withholds ready
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
    tx_ready <= !slow;
  end

  // Check arithmetic
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c[7:0] = c[7:0] ^ b[i];
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction
  function automatic logic [7:0] lrc(input logic [7:0] b[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s += b[i];
    return -s;
  endfunction
  function automatic logic [7:0] hex(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction

  // Frame a message; bad spoils the first byte after the check is made
  task automatic build(input logic m, input logic [7:0] b[$],
                       input logic bad, output logic [7:0] f[$]);
    logic [15:0] c;
    logic [7:0]  q[$];
    q = b;
    c = crc16(b);
    q.push_back(m ? c[7:0] : lrc(b));
    if (m) q.push_back(c[15:8]);
    q[0] ^= {7'h0, bad};
    f = q;
    if (!m) begin
      f = {8'h3a};
      foreach (q[i]) begin
        f.push_back(hex(q[i][7:4]));
        f.push_back(hex(q[i][3:0]));
      end
      f.push_back(8'h0d);
      f.push_back(8'h0a);
    end
  endtask

  // Quiet line first, then hold each character until it is taken
  task automatic send(input logic [7:0] f[$]);
    repeat (GAP + 2) @(posedge clk);
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= f[i];
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule

// *** dv/sfcu_props.sv ***
// ================================================================
// Port-level properties of the frame check unit
module sfcu_props #(
  parameter int GAP_CYCLES = 100000
) (
  // Clock and control
  input wire logic       SYS_CLK,
  input wire logic       SYS_RST,
  input wire logic       CLK_EN,
  input wire logic       MODE_RTU,
  // Receive side
  input wire logic       RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic       RX_READY,
  input wire logic       RX_BYTE_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic       RX_FRAME_OK,
  input wire logic       RX_FRAME_ERR,
  // Transmit side
  input wire logic       TX_IN_VALID,
  input wire logic [7:0] TX_IN_DATA,
  input wire logic       TX_IN_LAST,
  input wire logic       TX_IN_READY,
  input wire logic       TX_OUT_VALID,
  input wire logic [7:0] TX_OUT_DATA,
  input wire logic       TX_OUT_READY
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        take;
  logic        vrd;
  logic [31:0] idle_reg;
  logic [31:0] idle_next;
  logic        frm_reg;
  logic        frm_next;

  // Character taken, and any verdict pulse
  assign take = RX_VALID && RX_READY && CLK_EN;
  assign vrd  = RX_FRAME_OK || RX_FRAME_ERR;

  // Idle count saturates so a long quiet spell never wraps to zero
  always_comb begin
    idle_next = idle_reg + {31'h0, ~&idle_reg};
    frm_next  = frm_reg;
    if (take) begin
      idle_next = 32'h0;
    end
    if (take && !MODE_RTU) begin
      frm_next = (RX_DATA == 8'h3a) || (frm_reg && RX_DATA != 8'h0a);
    end
  end

  // Helper registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idle_reg <= 32'h0;
      frm_reg  <= 1'b0;
    end else begin
      idle_reg <= idle_next;
      frm_reg  <= frm_next;
    end
  end

  default clocking dck @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ================================================================
  // Properties
  a_bin_stall: assert property (
    take && MODE_RTU |=> !RX_READY [*8] ##1 RX_READY)
    else $error("binary byte not followed by eight busy cycles");
  a_bin_echo: assert property (
    take && MODE_RTU |=> RX_BYTE_VALID && RX_BYTE == $past(RX_DATA))
    else $error("binary byte not passed on");
  a_bin_gap: assert property (
    MODE_RTU && vrd |-> idle_reg >= GAP_CYCLES && idle_reg <= GAP_CYCLES + 16)
    else $error("binary verdict outside the idle gap");
  a_text_end: assert property (
    frm_reg && take && !MODE_RTU && RX_DATA == 8'h0a |=> vrd)
    else $error("text frame end without verdict");
  a_vrd_pulse: assert property (
    vrd |-> !(RX_FRAME_OK && RX_FRAME_ERR) ##1 !vrd)
    else $error("verdict not a single clean pulse");
  a_text_chars: assert property (
    TX_OUT_VALID && !MODE_RTU |-> TX_OUT_DATA inside
      {8'h3a, 8'h0d, 8'h0a, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("text output char not framing or uppercase hex");
  a_tx_hold: assert property (
    TX_OUT_VALID && !TX_OUT_READY |=> TX_OUT_VALID && $stable(TX_OUT_DATA))
    else $error("output char withdrawn or changed before taken");
  a_tx_drop: assert property (
    TX_OUT_VALID && TX_OUT_READY |=> !TX_OUT_VALID)
    else $error("output valid not dropped after a take");
endmodule

bind sfcu_top sfcu_props #(.GAP_CYCLES(GAP_CYCLES)) u_props (.*);

// *** dv/tb.sv ***
// ================================================================
// Self-checking bench for the frame check unit
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 50;
  typedef struct packed {logic m; logic ok; logic [47:0] b;} sfcu_row_t;
  logic       SYS_CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic       CLK_EN = 1'b1;
  logic       MODE_RTU = 1'b0;
  logic       TX_IN_VALID = 1'b0;
  logic [7:0] TX_IN_DATA = 8'h00;
  logic       TX_IN_LAST = 1'b0;
  logic       RX_VALID, RX_READY, RX_BYTE_VALID, RX_FRAME_OK, RX_FRAME_ERR;
  logic       TX_IN_READY, TX_OUT_VALID, TX_OUT_READY;
  logic [7:0] RX_DATA, RX_BYTE, TX_OUT_DATA;
  logic [7:0] rxb[$];
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         n_ok = 0;
  int         n_err = 0;
  // Mode, expected verdict, message bytes
  sfcu_row_t  rows[6] = '{
    {1'b0, 1'b1, 48'h7f0305c40001}, {1'b1, 1'b1, 48'h010301010002},
    {1'b0, 1'b0, 48'h010602000064}, {1'b1, 1'b0, 48'h011001120002},
    {1'b1, 1'b1, 48'h010602000064}, {1'b0, 1'b1, 48'h010302000002}};

  always #50 SYS_CLK = ~SYS_CLK;

  sfcu_top #(.GAP_CYCLES(GAP), .FIFO_DEPTH(8)) dut (.*);
  sfcu_host #(.GAP(GAP)) host (
    .clk(SYS_CLK), .rx_valid(RX_VALID), .rx_data(RX_DATA),
    .rx_ready(RX_READY), .tx_valid(TX_OUT_VALID), .tx_data(TX_OUT_DATA),
    .tx_ready(TX_OUT_READY));

  // Record receiver reports; the cycle ceiling cuts a hang short
  always @(posedge SYS_CLK) begin
    if (RX_BYTE_VALID === 1'b1) rxb.push_back(RX_BYTE);
    n_ok += int'(RX_FRAME_OK === 1'b1);
    n_err += int'(RX_FRAME_ERR === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Sends one frame and expects exactly one verdict of the given kind
  task automatic rx_frame(input logic [7:0] f[$], input logic ok);
    rxb = {};
    n_ok = 0;
    n_err = 0;
    host.send(f);
    for (int i = 0; i < GAP + 40 && n_ok + n_err == 0; i++) @(posedge SYS_CLK);
    repeat (2) @(posedge SYS_CLK);
    check("frame ok", 16'(n_ok), {15'h0, ok});
    check("frame err", 16'(n_err), {15'h0, !ok});
  endtask

  // Valid is left high so back-to-back bytes never re-raise it
  task automatic push(input logic [7:0] d, input logic last);
    TX_IN_VALID <= 1'b1;
    TX_IN_DATA  <= d;
    TX_IN_LAST  <= last;
    @(posedge SYS_CLK);
    while (TX_IN_READY !== 1'b1) @(posedge SYS_CLK);
  endtask

  task automatic tx_expect(input logic m, input logic [7:0] bq[$]);
    logic [7:0] f[$];
    host.build(m, bq, 1'b0, f);
    for (int i = 0; i < 600 && host.got.size() < f.size(); i++)
      @(posedge SYS_CLK);
    repeat (20) @(posedge SYS_CLK);
    check("tx count", 16'(host.got.size()), 16'(f.size()));
    foreach (f[i]) check("tx char", {8'h0, host.got[i]}, {8'h0, f[i]});
    host.got = {};
  endtask

  task automatic reset_pulse();
    SYS_RST <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    check("reset outs", {10'h0, RX_READY, RX_BYTE_VALID, RX_FRAME_OK,
          RX_FRAME_ERR, TX_IN_READY, TX_OUT_VALID}, 16'h0002);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    check("ready after reset", {15'h0, RX_READY}, 16'h0001);
  endtask

  // ================================================================
  // Main sequence
  initial begin
    logic [7:0] bq[$];
    logic [7:0] f[$];
    logic [7:0] eb[$];
    int n;
    reset_pulse();
    foreach (rows[r]) begin
      bq = {};
      for (int i = 0; i < 6; i++) bq.push_back(rows[r].b[47-8*i -: 8]);
      MODE_RTU <= rows[r].m;
      host.build(rows[r].m, bq, !rows[r].ok, f);
      rx_frame(f, rows[r].ok);
      eb = f;
      if (!rows[r].m) eb = bq;
      if (!rows[r].m) eb.push_back(host.lrc(bq));
      if (rows[r].ok) check("rx count", 16'(rxb.size()), 16'(eb.size()));
      foreach (eb[i]) if (rows[r].ok) check("rx byte", rxb[i], eb[i]);
      foreach (bq[i]) push(bq[i], i == 5);
      TX_IN_VALID <= 1'b0;
      tx_expect(rows[r].m, bq);
    end
    // Malformed text: lowercase digit, odd digit count
    MODE_RTU <= 1'b0;
    rx_frame('{8'h3a, 8'h30, 8'h61, 8'h0d, 8'h0a}, 1'b0);
    rx_frame('{8'h3a, 8'h30, 8'h31, 8'h32, 8'h0d, 8'h0a}, 1'b0);
    // Binary length boundary: two bytes fail, one byte plus its check passes
    MODE_RTU <= 1'b1;
    rx_frame('{8'h01, 8'h03}, 1'b0);
    host.build(1'b1, '{8'h11}, 1'b0, f);
    rx_frame(f, 1'b1);
    // Fill the buffer against a stalled reader, then drain it
    MODE_RTU <= 1'b0;
    host.slow <= 1'b1;
    n = 0;
    TX_IN_VALID <= 1'b1;
    TX_IN_DATA <= 8'h00;
    TX_IN_LAST <= 1'b0;
    repeat (12) begin
      @(posedge SYS_CLK);
      if (TX_IN_READY === 1'b1) n++;
      TX_IN_DATA <= n[7:0];
      TX_IN_LAST <= (n == 7);
    end
    TX_IN_VALID <= 1'b0;
    check("fifo fill", 16'(n), 16'h0008);
    check("stalled char", {7'h0, TX_OUT_VALID, TX_OUT_DATA}, 16'h013a);
    host.slow <= 1'b0;
    tx_expect(1'b0, '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7});
    // Reset in mid-frame drops the pending output
    host.slow <= 1'b1;
    push(8'h55, 1'b1);
    TX_IN_VALID <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    reset_pulse();
    host.slow <= 1'b0;
    repeat (GAP + 20) @(posedge SYS_CLK);
    check("tx after reset", 16'(host.got.size()), 16'h0000);
    end_sim();
  end
endmodule

// *** rtl/sfcu_defines.svh ***
`ifndef SFCU_DEFINES_SVH
`define SFCU_DEFINES_SVH

// ==================================================================
// Check arithmetic
`define SFCU_CRC_PRESET   16'hffff
`define SFCU_CRC_POLY     16'ha001
`define SFCU_CRC_GOOD     16'h0000
`define SFCU_LRC_GOOD     8'h00
`define SFCU_LAST_SHIFT   3'h7
`define SFCU_MIN_RTU      2'h3

// ==================================================================
// Characters of the text framing
`define SFCU_CHAR_COLON   8'h3a
`define SFCU_CHAR_CR      8'h0d
`define SFCU_CHAR_LF      8'h0a
`define SFCU_CHAR_ZERO    8'h30
`define SFCU_CHAR_NINE    8'h39
`define SFCU_CHAR_UA      8'h41
`define SFCU_CHAR_UF      8'h46
`define SFCU_HEX_ALPHA    8'h37

// ==================================================================
// Timing
`define SFCU_CLK_HZ       10000000
`define SFCU_GAP_MS       10
`define SFCU_GAP_CYCLES   ((`SFCU_GAP_MS * `SFCU_CLK_HZ) / 1000)
`define SFCU_FIFO_DEPTH   8

`endif

// *** rtl/sfcu_fifo.sv ***
module sfcu_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             full_reg;
  logic             full_next;
  logic             empty_reg;
  logic             empty_next;
  logic             push;
  logic             pop;

  // ================================================================
  // Pointer and flag update; flags are flops so ready is glitch free
  always_comb begin
    push       = in_valid && !full_reg;
    pop        = out_ready && !empty_reg;
    wr_next    = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next    = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next   = cnt_reg;
    if (push && !pop) begin
      cnt_next = CW'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = CW'(cnt_reg - 1'b1);
    end
    full_next  = (cnt_next == CW'(DEPTH));
    empty_next = (cnt_next == '0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      cnt_reg   <= '0;
      full_reg  <= 1'b0;
      empty_reg <= 1'b1;
    end else if (ce) begin
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      cnt_reg   <= cnt_next;
      full_reg  <= full_next;
      empty_reg <= empty_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data  = mem[rd_reg];

endmodule

// *** rtl/sfcu_pkg.sv ***
package sfcu_pkg;

  // ================================================================
  // Receive states
  typedef enum logic [0:0] {
    RX_IDLE,
    RX_SHIFT
  } sfcu_rx_state_t;

  // ================================================================
  // Transmit states
  typedef enum logic [3:0] {
    TX_IDLE,
    TX_COLON,
    TX_FETCH,
    TX_RAW,
    TX_SHIFT,
    TX_CRC_L,
    TX_CRC_H,
    TX_NIB_H,
    TX_NIB_L,
    TX_LRC_H,
    TX_LRC_L,
    TX_CR,
    TX_LF
  } sfcu_tx_state_t;

endpackage

// *** rtl/sfcu_top.sv ***
`include "sfcu_defines.svh"

module sfcu_top
  import sfcu_pkg::*;
#(
  parameter int GAP_CYCLES = `SFCU_GAP_CYCLES,
  parameter int FIFO_DEPTH = `SFCU_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CLK_EN,
  // Mode select: high for binary framing
  input  wire logic       MODE_RTU,
  // Receive characters from the line logic
  input  wire logic       RX_VALID,
  input  wire logic [7:0] RX_DATA,
  output logic            RX_READY,
  // Received message bytes and verdict
  output logic            RX_BYTE_VALID,
  output logic [7:0]      RX_BYTE,
  output logic            RX_FRAME_OK,
  output logic            RX_FRAME_ERR,
  // Transmit message bytes
  input  wire logic       TX_IN_VALID,
  input  wire logic [7:0] TX_IN_DATA,
  input  wire logic       TX_IN_LAST,
  output logic            TX_IN_READY,
  // Transmit characters to the line logic
  output logic            TX_OUT_VALID,
  output logic [7:0]      TX_OUT_DATA,
  input  wire logic       TX_OUT_READY
);

  localparam int GW = $clog2(GAP_CYCLES + 1);

  // ================================================================
  // Shared arithmetic
  function automatic logic [15:0] crc_shift(input logic [15:0] c);
    if (c[0]) begin
      crc_shift = (c >> 1) ^ `SFCU_CRC_POLY;
    end else begin
      crc_shift = c >> 1;
    end
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < 4'ha) begin
      hex_char = `SFCU_CHAR_ZERO + {4'h0, n};
    end else begin
      hex_char = `SFCU_HEX_ALPHA + {4'h0, n};
    end
  endfunction

  // Returns {valid, nibble}; lower case is rejected on purpose
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    hex_val = 5'h00;
    if (c >= `SFCU_CHAR_ZERO && c <= `SFCU_CHAR_NINE) begin
      d = c - `SFCU_CHAR_ZERO;
      hex_val = {1'b1, d[3:0]};
    end else if (c >= `SFCU_CHAR_UA && c <= `SFCU_CHAR_UF) begin
      d = c - `SFCU_HEX_ALPHA;
      hex_val = {1'b1, d[3:0]};
    end
  endfunction

  // ================================================================
  // Receive checker state
  sfcu_rx_state_t rx_state_reg, rx_state_next;
  logic [15:0] rx_crc_reg, rx_crc_next;
  logic [7:0]  rx_lrc_reg, rx_lrc_next;
  logic [2:0]  rx_cnt_reg, rx_cnt_next;
  logic [GW-1:0] rx_gap_reg, rx_gap_next;
  logic        rx_act_reg, rx_act_next;
  logic        rx_rtu_reg, rx_rtu_next;
  logic        rx_phase_reg, rx_phase_next;
  logic [3:0]  rx_hi_reg, rx_hi_next;
  logic        rx_bad_reg, rx_bad_next;
  logic [1:0]  rx_nb_reg, rx_nb_next;
  logic        rx_rdy_reg, rx_rdy_next;
  logic        rx_bv_reg, rx_bv_next;
  logic [7:0]  rx_byte_reg, rx_byte_next;
  logic        rx_ok_reg, rx_ok_next;
  logic        rx_err_reg, rx_err_next;
  logic        rx_take;
  logic        rx_rtu;
  logic [4:0]  rx_hex;
  logic [7:0]  rx_dec;

  // Receive next state; byte count saturates, only a minimum matters
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_crc_next   = rx_crc_reg;
    rx_lrc_next   = rx_lrc_reg;
    rx_cnt_next   = rx_cnt_reg;
    rx_act_next   = rx_act_reg;
    rx_rtu_next   = rx_rtu_reg;
    rx_phase_next = rx_phase_reg;
    rx_hi_next    = rx_hi_reg;
    rx_bad_next   = rx_bad_reg;
    rx_nb_next    = rx_nb_reg;
    rx_bv_next    = 1'b0;
    rx_byte_next  = rx_byte_reg;
    rx_ok_next    = 1'b0;
    rx_err_next   = 1'b0;
    rx_take       = RX_VALID && rx_rdy_reg;
    rx_rtu        = rx_act_reg ? rx_rtu_reg : MODE_RTU;
    rx_hex        = hex_val(RX_DATA);
    rx_dec        = {rx_hi_reg, rx_hex[3:0]};
    rx_gap_next   = (rx_gap_reg == GW'(GAP_CYCLES)) ? rx_gap_reg
                  : GW'(rx_gap_reg + 1'b1);
    unique case (rx_state_reg)
      RX_IDLE: begin
        if (rx_take) begin
          rx_gap_next = '0;
          if (rx_rtu) begin
            rx_rtu_next   = 1'b1;
            rx_act_next   = 1'b1;
            rx_crc_next   = (rx_act_reg ? rx_crc_reg : `SFCU_CRC_PRESET)
                          ^ {8'h00, RX_DATA};
            rx_nb_next    = (rx_act_reg && rx_nb_reg == `SFCU_MIN_RTU)
                          ? rx_nb_reg
                          : (rx_act_reg ? 2'(rx_nb_reg + 1'b1) : 2'h1);
            rx_cnt_next   = 3'h0;
            rx_bv_next    = 1'b1;
            rx_byte_next  = RX_DATA;
            rx_state_next = RX_SHIFT;
          end else if (RX_DATA == `SFCU_CHAR_COLON) begin
            rx_rtu_next   = 1'b0;
            rx_act_next   = 1'b1;
            rx_lrc_next   = 8'h00;
            rx_phase_next = 1'b0;
            rx_bad_next   = 1'b0;
            rx_nb_next    = 2'h0;
          end else if (!rx_act_reg || RX_DATA == `SFCU_CHAR_CR) begin
            rx_act_next   = rx_act_reg;
          end else if (RX_DATA == `SFCU_CHAR_LF) begin
            rx_act_next   = 1'b0;
            if (!rx_bad_reg && !rx_phase_reg && rx_nb_reg != 2'h0 &&
                rx_lrc_reg == `SFCU_LRC_GOOD) begin
              rx_ok_next  = 1'b1;
            end else begin
              rx_err_next = 1'b1;
            end
          end else if (!rx_hex[4]) begin
            rx_bad_next   = 1'b1;
          end else if (!rx_phase_reg) begin
            rx_hi_next    = rx_hex[3:0];
            rx_phase_next = 1'b1;
          end else begin
            rx_phase_next = 1'b0;
            rx_lrc_next   = rx_lrc_reg + rx_dec;
            rx_nb_next    = (rx_nb_reg == 2'h3) ? rx_nb_reg
                          : 2'(rx_nb_reg + 1'b1);
            rx_bv_next    = 1'b1;
            rx_byte_next  = rx_dec;
          end
        end else if (rx_act_reg && rx_rtu_reg &&
                     rx_gap_reg == GW'(GAP_CYCLES)) begin
          rx_act_next = 1'b0;
          if (rx_crc_reg == `SFCU_CRC_GOOD &&
              rx_nb_reg == `SFCU_MIN_RTU) begin
            rx_ok_next  = 1'b1;
          end else begin
            rx_err_next = 1'b1;
          end
        end
      end
      RX_SHIFT: begin
        rx_crc_next = crc_shift(rx_crc_reg);
        rx_cnt_next = 3'(rx_cnt_reg + 1'b1);
        if (rx_cnt_reg == `SFCU_LAST_SHIFT) begin
          rx_state_next = RX_IDLE;
        end
      end
    endcase
    rx_rdy_next = (rx_state_next == RX_IDLE);
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_state_reg <= RX_IDLE;
      rx_crc_reg   <= `SFCU_CRC_PRESET;
      rx_lrc_reg   <= 8'h00;
      rx_cnt_reg   <= 3'h0;
      rx_gap_reg   <= '0;
      rx_act_reg   <= 1'b0;
      rx_rtu_reg   <= 1'b0;
      rx_phase_reg <= 1'b0;
      rx_hi_reg    <= 4'h0;
      rx_bad_reg   <= 1'b0;
      rx_nb_reg    <= 2'h0;
      rx_rdy_reg   <= 1'b0;
      rx_bv_reg    <= 1'b0;
      rx_byte_reg  <= 8'h00;
      rx_ok_reg    <= 1'b0;
      rx_err_reg   <= 1'b0;
    end else if (CLK_EN) begin
      rx_state_reg <= rx_state_next;
      rx_crc_reg   <= rx_crc_next;
      rx_lrc_reg   <= rx_lrc_next;
      rx_cnt_reg   <= rx_cnt_next;
      rx_gap_reg   <= rx_gap_next;
      rx_act_reg   <= rx_act_next;
      rx_rtu_reg   <= rx_rtu_next;
      rx_phase_reg <= rx_phase_next;
      rx_hi_reg    <= rx_hi_next;
      rx_bad_reg   <= rx_bad_next;
      rx_nb_reg    <= rx_nb_next;
      rx_rdy_reg   <= rx_rdy_next;
      rx_bv_reg    <= rx_bv_next;
      rx_byte_reg  <= rx_byte_next;
      rx_ok_reg    <= rx_ok_next;
      rx_err_reg   <= rx_err_next;
    end
  end

  // ================================================================
  // Transmit FIFO; a stalled line backs up into TX_IN_READY
  logic       f_valid;
  logic [8:0] f_data;
  logic       f_pop;

  sfcu_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .ce        (CLK_EN),
    .in_valid  (TX_IN_VALID),
    .in_data   ({TX_IN_LAST, TX_IN_DATA}),
    .in_ready  (TX_IN_READY),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  // ================================================================
  // Transmit generator state
  sfcu_tx_state_t tx_state_reg, tx_state_next;
  logic [15:0] tx_crc_reg, tx_crc_next;
  logic [7:0]  tx_lrc_reg, tx_lrc_next;
  logic [2:0]  tx_cnt_reg, tx_cnt_next;
  logic [GW-1:0] tx_gap_reg, tx_gap_next;
  logic [7:0]  tx_cur_reg, tx_cur_next;
  logic        tx_last_reg, tx_last_next;
  logic        tx_rtu_reg, tx_rtu_next;
  logic        tx_ov_reg, tx_ov_next;
  logic [7:0]  tx_od_reg, tx_od_next;
  logic [7:0]  tx_chk;
  logic [7:0]  tx_char;
  logic        tx_emit;
  logic        tx_done;

  // Mid-frame FIFO underrun can stretch a binary frame past the gap;
  // the source must keep a binary frame's bytes flowing
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_crc_next   = tx_crc_reg;
    tx_lrc_next   = tx_lrc_reg;
    tx_cnt_next   = tx_cnt_reg;
    tx_cur_next   = tx_cur_reg;
    tx_last_next  = tx_last_reg;
    tx_ov_next    = tx_ov_reg;
    tx_od_next    = tx_od_reg;
    f_pop         = 1'b0;
    tx_chk        = (~tx_lrc_reg) + 8'h01;
    tx_done       = tx_ov_reg && TX_OUT_READY;
    tx_gap_next   = tx_done ? '0
                  : (tx_gap_reg == GW'(GAP_CYCLES)) ? tx_gap_reg
                  : GW'(tx_gap_reg + 1'b1);
    tx_emit       = 1'b1;
    tx_char       = 8'h00;
    unique case (tx_state_reg)
      TX_COLON: tx_char = `SFCU_CHAR_COLON;
      TX_RAW:   tx_char = tx_cur_reg;
      TX_CRC_L: tx_char = tx_crc_reg[7:0];
      TX_CRC_H: tx_char = tx_crc_reg[15:8];
      TX_NIB_H: tx_char = hex_char(tx_cur_reg[7:4]);
      TX_NIB_L: tx_char = hex_char(tx_cur_reg[3:0]);
      TX_LRC_H: tx_char = hex_char(tx_chk[7:4]);
      TX_LRC_L: tx_char = hex_char(tx_chk[3:0]);
      TX_CR:    tx_char = `SFCU_CHAR_CR;
      TX_LF:    tx_char = `SFCU_CHAR_LF;
      default:  tx_emit = 1'b0;
    endcase
    if (tx_emit && !tx_ov_reg) begin
      tx_ov_next = 1'b1;
      tx_od_next = tx_char;
    end else if (tx_done) begin
      tx_ov_next = 1'b0;
    end
    unique case (tx_state_reg)
      TX_IDLE: begin
        if (f_valid && (!MODE_RTU ||
            tx_gap_reg == GW'(GAP_CYCLES))) begin
          tx_crc_next   = `SFCU_CRC_PRESET;
          tx_lrc_next   = 8'h00;
          tx_state_next = MODE_RTU ? TX_FETCH : TX_COLON;
        end
      end
      TX_FETCH: begin
        if (f_valid) begin
          f_pop         = 1'b1;
          tx_cur_next   = f_data[7:0];
          tx_last_next  = f_data[8];
          tx_state_next = tx_rtu_reg ? TX_RAW : TX_NIB_H;
        end
      end
      TX_RAW: begin
        if (tx_done) begin
          tx_crc_next   = tx_crc_reg ^ {8'h00, tx_cur_reg};
          tx_cnt_next   = 3'h0;
          tx_state_next = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        tx_crc_next = crc_shift(tx_crc_reg);
        tx_cnt_next = 3'(tx_cnt_reg + 1'b1);
        if (tx_cnt_reg == `SFCU_LAST_SHIFT) begin
          tx_state_next = tx_last_reg ? TX_CRC_L : TX_FETCH;
        end
      end
      TX_NIB_L: begin
        if (tx_done) begin
          tx_lrc_next   = tx_lrc_reg + tx_cur_reg;
          tx_state_next = tx_last_reg ? TX_LRC_H : TX_FETCH;
        end
      end
      TX_COLON: if (tx_done) tx_state_next = TX_FETCH;
      TX_CRC_L: if (tx_done) tx_state_next = TX_CRC_H;
      TX_CRC_H: if (tx_done) tx_state_next = TX_IDLE;
      TX_NIB_H: if (tx_done) tx_state_next = TX_NIB_L;
      TX_LRC_H: if (tx_done) tx_state_next = TX_LRC_L;
      TX_LRC_L: if (tx_done) tx_state_next = TX_CR;
      TX_CR:    if (tx_done) tx_state_next = TX_LF;
      TX_LF:    if (tx_done) tx_state_next = TX_IDLE;
    endcase
  end

  // Mode is latched on leaving idle so a mid-frame change cannot split it
  always_comb begin
    tx_rtu_next = tx_rtu_reg;
    if (tx_state_reg == TX_IDLE && tx_state_next != TX_IDLE) begin
      tx_rtu_next = MODE_RTU;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_state_reg <= TX_IDLE;
      tx_crc_reg   <= `SFCU_CRC_PRESET;
      tx_lrc_reg   <= 8'h00;
      tx_cnt_reg   <= 3'h0;
      tx_gap_reg   <= '0;
      tx_cur_reg   <= 8'h00;
      tx_last_reg  <= 1'b0;
      tx_ov_reg    <= 1'b0;
      tx_od_reg    <= 8'h00;
      tx_rtu_reg   <= 1'b0;
    end else if (CLK_EN) begin
      tx_state_reg <= tx_state_next;
      tx_crc_reg   <= tx_crc_next;
      tx_lrc_reg   <= tx_lrc_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_gap_reg   <= tx_gap_next;
      tx_cur_reg   <= tx_cur_next;
      tx_last_reg  <= tx_last_next;
      tx_ov_reg    <= tx_ov_next;
      tx_od_reg    <= tx_od_next;
      tx_rtu_reg   <= tx_rtu_next;
    end
  end

  // ================================================================
  // Outputs, all straight from flops
  assign RX_READY      = rx_rdy_reg;
  assign RX_BYTE_VALID = rx_bv_reg;
  assign RX_BYTE       = rx_byte_reg;
  assign RX_FRAME_OK   = rx_ok_reg;
  assign RX_FRAME_ERR  = rx_err_reg;
  assign TX_OUT_VALID  = tx_ov_reg;
  assign TX_OUT_DATA   = tx_od_reg;

endmodule
